/* verilog/acc_pkg.sv */
`default_nettype none
package acc_pkg;
  // ----------------------------------------------------------------
  // Register map (printed offsets are indices, byte address is 4x)
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] IDX_CONTROL_0   = 12'h0E8;
  localparam logic [11:0] IDX_CONTROL_1   = 12'h0B2;
  localparam logic [11:0] IDX_CONFIG      = 12'h0BC;
  localparam logic [11:0] ADDR_CONTROL_0  = IDX_CONTROL_0 << 2;
  localparam logic [11:0] ADDR_CONTROL_1  = IDX_CONTROL_1 << 2;
  localparam logic [11:0] ADDR_CONFIG     = IDX_CONFIG << 2;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          BIT_ENABLE      = 7;
  localparam int          BIT_BURST       = 6;
  localparam int          BIT_DONE        = 5;
  localparam int          BIT_BUSY        = 4;
  localparam int          BIT_WINDOW      = 3;
  localparam int          SRC_HI          = 2;
  localparam int          SRC_LO          = 0;
  localparam int          BIT_CM_BUF      = 0;
  localparam int          DIV_HI          = 7;
  localparam int          DIV_LO          = 3;
  localparam int          BIT_EIGHT       = 2;
  localparam int          BIT_TRACK       = 1;
  localparam int          BIT_GAIN        = 0;
  localparam logic [7:0]  RST_CONTROL_0   = 8'h00;
  localparam logic [7:0]  RST_CONTROL_1   = 8'h00;
  localparam logic [7:0]  RST_CONFIG      = 8'hF8;

  // ----------------------------------------------------------------
  // Start sources, timing, bus answers
  // ----------------------------------------------------------------
  localparam logic [2:0]  SRC_SOFTWARE    = 3'h0;
  localparam logic [2:0]  SRC_TIMER0      = 3'h1;
  localparam logic [2:0]  SRC_TIMER2      = 3'h2;
  localparam logic [2:0]  SRC_TIMER3      = 3'h3;
  localparam logic [2:0]  SRC_EXT_PIN     = 3'h4;
  localparam logic [1:0]  TRACK_DELAY_MAX = 2'h3;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONVERT} acc_state_e;
endpackage : acc_pkg
`default_nettype wire

/* verilog/acc_adc_control.sv */
// Implementation choice: register access over AXI4-Lite.
`default_nettype none
module acc_adc_control
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Start triggers and burst-mode bit clock tick
  input  wire logic        timer0_overflow,
  input  wire logic        timer2_overflow,
  input  wire logic        timer3_overflow,
  input  wire logic        external_convert_start_pin,
  input  wire logic        hfosc_tick,
  // Analog core
  input  wire logic        sar_done,
  input  wire logic        sar_burst_last,
  input  wire logic        window_match,
  output logic             converter_powered,
  output logic             burst_enable,
  output logic             common_mode_buffer_enable,
  output logic             eight_bit_select,
  output logic             input_gain_select,
  output logic             tracking,
  output logic             sar_bit_clk_en,
  output logic             conv_start
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0]          ctrl0_q;
  logic                cm_buf_q;
  logic [7:0]          config_q;
  acc_pkg::acc_state_e state_q;
  logic [1:0]          dly_q;
  logic [4:0]          div_cnt_q;
  logic                bit_tick_q;
  logic                conv_start_q;
  logic                pin_s1_q;
  logic                pin_s2_q;
  logic                pin_s3_q;
  logic                aw_held_q;
  logic                w_held_q;
  logic [11:0]         aw_addr_q;
  logic [31:0]         w_data_q;
  logic                w_lane0_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;

  logic       enabled;
  logic       burst_on;
  logic [2:0] source;
  logic       do_write;
  logic       wr_ctrl0;
  logic       src_tick;
  logic       bit_tick;
  logic       ext_rise;
  logic       start_req;
  logic       done_set;
  logic       sw_start;

  assign enabled   = ctrl0_q[acc_pkg::BIT_ENABLE];
  assign burst_on  = ctrl0_q[acc_pkg::BIT_BURST];
  assign source    = ctrl0_q[acc_pkg::SRC_HI:acc_pkg::SRC_LO];

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign awready  = !aw_held_q && !bvalid_q;
  assign wready   = !w_held_q && !bvalid_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign wr_ctrl0 = do_write && w_lane0_q && (aw_addr_q == acc_pkg::ADDR_CONTROL_0);
  assign bvalid   = bvalid_q;
  assign bresp    = bresp_q;
  assign arready  = !rvalid_q;
  assign rvalid   = rvalid_q;
  assign rdata    = rdata_q;
  assign rresp    = rresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q  <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= acc_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= {awaddr[11:2], 2'h0};
      end
      if (wvalid && wready)
      begin
        w_held_q  <= 1'b1;
        w_data_q  <= wdata;
        w_lane0_q <= wstrb[0];
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        if (aw_addr_q == acc_pkg::ADDR_CONTROL_0 || aw_addr_q == acc_pkg::ADDR_CONTROL_1 ||
            aw_addr_q == acc_pkg::ADDR_CONFIG)
          bresp_q <= acc_pkg::RESP_OKAY;
        else
          bresp_q <= acc_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= acc_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= acc_pkg::RESP_OKAY;
      if ({araddr[11:2], 2'h0} == acc_pkg::ADDR_CONTROL_0)
        // Busy bit shows the live sequencer state
        rdata_q <= {24'h000000, ctrl0_q[7:5], state_q != acc_pkg::ST_IDLE, ctrl0_q[3:0]};
      else if ({araddr[11:2], 2'h0} == acc_pkg::ADDR_CONTROL_1)
        rdata_q <= {31'h0000_0000, cm_buf_q};
      else if ({araddr[11:2], 2'h0} == acc_pkg::ADDR_CONFIG)
        rdata_q <= {24'h000000, config_q};
      else
      begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= acc_pkg::RESP_SLVERR;
      end
    end
    else if (rvalid_q && rready)
      rvalid_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Control 0: mode bits and sticky flags
  // ----------------------------------------------------------------
  assign done_set = sar_done && state_q == acc_pkg::ST_CONVERT && (!burst_on || sar_burst_last);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl0_q <= acc_pkg::RST_CONTROL_0;
    else
    begin
      if (wr_ctrl0)
      begin
        ctrl0_q[7:6] <= w_data_q[7:6];
        ctrl0_q[2:0] <= w_data_q[2:0];
      end
      ctrl0_q[acc_pkg::BIT_DONE] <= done_set ||
        (wr_ctrl0 ? w_data_q[acc_pkg::BIT_DONE] : ctrl0_q[acc_pkg::BIT_DONE]);
      ctrl0_q[acc_pkg::BIT_WINDOW] <= (window_match && enabled) ||
        (wr_ctrl0 ? w_data_q[acc_pkg::BIT_WINDOW] : ctrl0_q[acc_pkg::BIT_WINDOW]);
      ctrl0_q[acc_pkg::BIT_BUSY] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control 1 and configuration
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cm_buf_q <= acc_pkg::RST_CONTROL_1[acc_pkg::BIT_CM_BUF];
      config_q <= acc_pkg::RST_CONFIG;
    end
    else if (do_write && w_lane0_q)
    begin
      if (aw_addr_q == acc_pkg::ADDR_CONTROL_1)
        cm_buf_q <= w_data_q[acc_pkg::BIT_CM_BUF];
      if (aw_addr_q == acc_pkg::ADDR_CONFIG)
        config_q <= w_data_q[7:0];
    end
  end

  assign converter_powered         = enabled;
  assign burst_enable              = burst_on;
  assign common_mode_buffer_enable = cm_buf_q;
  assign eight_bit_select          = config_q[acc_pkg::BIT_EIGHT];
  assign input_gain_select         = config_q[acc_pkg::BIT_GAIN];

  // ----------------------------------------------------------------
  // Bit clock divider
  // ----------------------------------------------------------------
  // source by burst
  assign src_tick = burst_on ? hfosc_tick : 1'b1;
  assign bit_tick = enabled && src_tick &&
                    (div_cnt_q == config_q[acc_pkg::DIV_HI:acc_pkg::DIV_LO]);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !enabled)
      div_cnt_q <= 5'h00;
    else if (bit_tick)
      div_cnt_q <= 5'h00;
    else if (src_tick)
      div_cnt_q <= div_cnt_q + 5'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bit_tick_q <= 1'b0;
    else
      bit_tick_q <= bit_tick;
  end

  assign sar_bit_clk_en = bit_tick_q;

  // ----------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------
  // pin synchroniser
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= external_convert_start_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign ext_rise = pin_s2_q && !pin_s3_q;
  assign sw_start = wr_ctrl0 && w_data_q[acc_pkg::BIT_BUSY];

  always_comb
  begin
    // source decode, reserved codes start nothing
    case (source)
      acc_pkg::SRC_SOFTWARE: start_req = sw_start;
      acc_pkg::SRC_TIMER0:   start_req = timer0_overflow;
      acc_pkg::SRC_TIMER2:   start_req = timer2_overflow;
      acc_pkg::SRC_TIMER3:   start_req = timer3_overflow;
      acc_pkg::SRC_EXT_PIN:  start_req = ext_rise;
      default:               start_req = 1'b0;
    endcase
    start_req = start_req && enabled;
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !enabled)
    begin
      state_q      <= acc_pkg::ST_IDLE;
      dly_q        <= 2'h0;
      conv_start_q <= 1'b0;
    end
    else
    begin
      conv_start_q <= 1'b0;
      case (state_q)
        acc_pkg::ST_IDLE:
          if (start_req)
          begin
            dly_q <= 2'h0;
            if (config_q[acc_pkg::BIT_TRACK])
              state_q <= acc_pkg::ST_TRACK;
            else
            begin
              state_q      <= acc_pkg::ST_CONVERT;
              conv_start_q <= 1'b1;
            end
          end
        acc_pkg::ST_TRACK:
          if (bit_tick)
          begin
            if (dly_q == acc_pkg::TRACK_DELAY_MAX)
            begin
              state_q      <= acc_pkg::ST_CONVERT;
              conv_start_q <= 1'b1;
            end
            else
              dly_q <= dly_q + 2'h1;
          end
        acc_pkg::ST_CONVERT:
          if (sar_done && (!burst_on || sar_burst_last))
            state_q <= acc_pkg::ST_IDLE;
        default:
          state_q <= acc_pkg::ST_IDLE;
      endcase
    end
  end

  assign tracking   = state_q == acc_pkg::ST_TRACK;
  assign conv_start = conv_start_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  done_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    done_set |=> ctrl0_q[acc_pkg::BIT_DONE]) else $error("done flag not set");
  window_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    window_match && enabled |=> ctrl0_q[acc_pkg::BIT_WINDOW]) else $error("window flag missed");
  sw_start_go_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_start && enabled && source == acc_pkg::SRC_SOFTWARE && state_q == acc_pkg::ST_IDLE
    |=> state_q != acc_pkg::ST_IDLE) else $error("software start ignored");
  disabled_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !enabled |=> state_q == acc_pkg::ST_IDLE && !conv_start_q) else $error("run while off");
  reserved_no_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == acc_pkg::ST_IDLE && source > acc_pkg::SRC_EXT_PIN
    |=> state_q == acc_pkg::ST_IDLE) else $error("reserved source started");
  ext_edge_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == acc_pkg::ST_IDLE && enabled && source == acc_pkg::SRC_EXT_PIN
    && $rose(pin_s2_q) |=> state_q != acc_pkg::ST_IDLE) else $error("pin edge missed");
  track_delay_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == acc_pkg::ST_TRACK && enabled && bit_tick && dly_q == acc_pkg::TRACK_DELAY_MAX
    |=> conv_start_q && state_q == acc_pkg::ST_CONVERT) else $error("track delay wrong");
  div_one_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bit_tick && !burst_on && config_q[acc_pkg::DIV_HI:acc_pkg::DIV_LO] == 5'h01
    && !(do_write && w_lane0_q)
    |=> !bit_tick ##1 (bit_tick || !enabled || burst_on
    || config_q[acc_pkg::DIV_HI:acc_pkg::DIV_LO] != 5'h01)) else $error("divider period");

endmodule : acc_adc_control
`default_nettype wire

/* verif/acc_adc_control_tb_top.sv */
`default_nettype none
module acc_adc_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------
  // Signals
  // --------------------------------
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, timer0_overflow, timer2_overflow;
  logic        timer3_overflow, external_convert_start_pin, hfosc_tick, sar_done;
  logic        sar_burst_last, window_match, converter_powered, burst_enable, tracking;
  logic        common_mode_buffer_enable, eight_bit_select, input_gain_select;
  logic        sar_bit_clk_en, conv_start;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rd_r;
  int          mismatches, compares, cyc, starts, last_tick, tick_gap, trk_ticks, s0;

  acc_adc_control uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .timer0_overflow, .timer2_overflow, .timer3_overflow,
    .external_convert_start_pin, .hfosc_tick, .sar_done, .sar_burst_last, .window_match,
    .converter_powered, .burst_enable, .common_mode_buffer_enable, .eight_bit_select,
    .input_gain_select, .tracking, .sar_bit_clk_en, .conv_start);

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // --------------------------------
  // Output monitor
  // --------------------------------
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (conv_start) starts <= starts + 1;
    if (sar_bit_clk_en)
    begin
      last_tick <= cyc;
      tick_gap  <= cyc - last_tick;
      if (tracking) trk_ticks <= trk_ticks + 1;
    end
  end

  // --------------------------------
  // Bus and helper tasks
  // --------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw_t, w_t, b_t;
    int   n;
    b_t = 1'b0;
    n = 0;
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!b_t && n < 50)
    begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t  = wvalid && wready;
      b_t  = bvalid && bready;
      rd_r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!b_t) chk("write answer", 1, 0);
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    logic ar_t, r_t;
    int   n;
    r_t = 1'b0;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!r_t && n < 50)
    begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      r_t  = rvalid && rready;
      rd_d = rdata;
      rd_r = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!r_t) chk("read answer", 1, 0);
    @(posedge aclk);
  endtask : rd

  task automatic fin(input logic last);
    sar_burst_last <= last;
    sar_done       <= 1'b1;
    @(posedge aclk);
    sar_done       <= 1'b0;
    @(posedge aclk);
  endtask : fin

  task automatic trig(input int s);
    if (s == 0) wr(acc_pkg::ADDR_CONTROL_0, 8'h90);
    timer0_overflow <= (s == 1 || s == 5);
    timer2_overflow <= (s == 2);
    timer3_overflow <= (s == 3);
    external_convert_start_pin <= (s >= 4);
    @(posedge aclk);
    {timer0_overflow, timer2_overflow, timer3_overflow} <= 3'h0;
    repeat (4) @(posedge aclk);
    external_convert_start_pin <= 1'b0;
  endtask : trig

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_reset;
    rd(acc_pkg::ADDR_CONTROL_0);
    chk("control 0", 32'h0, rd_d);
    rd(acc_pkg::ADDR_CONTROL_1);
    chk("control 1", 32'h0, rd_d);
    rd(acc_pkg::ADDR_CONFIG);
    chk("config", 32'hF8, rd_d);
    chk("powered", 0, converter_powered);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs;
    wr(acc_pkg::ADDR_CONFIG, 8'h05);
    chk("config wresp", acc_pkg::RESP_OKAY, rd_r);
    rd(acc_pkg::ADDR_CONFIG);
    chk("config", 32'h05, rd_d);
    chk("eight bit", 1, {eight_bit_select, input_gain_select} == 2'h3);
    wr(acc_pkg::ADDR_CONTROL_1, 8'h01);
    rd(acc_pkg::ADDR_CONTROL_1);
    chk("control 1", 32'h01, rd_d);
    chk("cm buffer", 1, common_mode_buffer_enable);
    wr(acc_pkg::ADDR_CONTROL_0, 8'hC0);
    chk("powered", 1, converter_powered && burst_enable);
    wr(acc_pkg::ADDR_CONTROL_0, 8'h00);
    chk("burst off", 0, burst_enable);
    wr(12'h000, 8'h00);
    chk("unmapped wresp", acc_pkg::RESP_SLVERR, rd_r);
    rd(12'h000);
    chk("unmapped resp", acc_pkg::RESP_SLVERR, rd_r);
    chk("unmapped data", 32'h0, rd_d);
    $display("test registers done");
  endtask : t_regs

  task automatic t_sources;
    for (int s = 0; s < 6; s++)
    begin
      wr(acc_pkg::ADDR_CONTROL_0, 8'h80 | s[7:0]);
      s0 = starts;
      trig(s);
      repeat (12) @(posedge aclk);
      chk("starts", (s < 5), starts - s0);
      if (s < 5) fin(1'b0);
      rd(acc_pkg::ADDR_CONTROL_0);
      chk("done flag", (s < 5) ? 8'hA0 | s[7:0] : 8'h85, rd_d);
      wr(acc_pkg::ADDR_CONTROL_0, 8'h00);
    end
    s0 = starts;
    wr(acc_pkg::ADDR_CONTROL_0, 8'h10);
    repeat (12) @(posedge aclk);
    chk("disabled start", 0, starts - s0);
    $display("test sources done");
  endtask : t_sources

  task automatic t_burst;
    wr(acc_pkg::ADDR_CONTROL_0, 8'hC0);
    s0 = starts;
    wr(acc_pkg::ADDR_CONTROL_0, 8'hD0);
    repeat (4) @(posedge aclk);
    chk("burst start", 1, starts - s0);
    fin(1'b0);
    rd(acc_pkg::ADDR_CONTROL_0);
    chk("mid burst", 32'hD0, rd_d);
    fin(1'b1);
    rd(acc_pkg::ADDR_CONTROL_0);
    chk("burst end", 32'hE0, rd_d);
    window_match <= 1'b1;
    @(posedge aclk);
    window_match <= 1'b0;
    rd(acc_pkg::ADDR_CONTROL_0);
    chk("window flag", 32'hE8, rd_d);
    wr(acc_pkg::ADDR_CONTROL_0, 8'hC0);
    rd(acc_pkg::ADDR_CONTROL_0);
    chk("flags cleared", 32'hC0, rd_d);
    repeat (4)
    begin
      hfosc_tick <= 1'b1;
      @(posedge aclk);
      hfosc_tick <= 1'b0;
      repeat (2) @(posedge aclk);
    end
    repeat (2) @(posedge aclk);
    chk("burst tick gap", 3, tick_gap);
    $display("test burst done");
  endtask : t_burst

  task automatic t_delay;
    wr(acc_pkg::ADDR_CONFIG, 8'h0A);
    wr(acc_pkg::ADDR_CONTROL_0, 8'h80);
    s0 = starts;
    trk_ticks = 0;
    wr(acc_pkg::ADDR_CONTROL_0, 8'h90);
    repeat (30) @(posedge aclk);
    chk("delayed start", 1, starts - s0);
    chk("track ticks", 1, trk_ticks inside {3, 4});
    chk("tick gap", 2, tick_gap);
    fin(1'b0);
    $display("test delayed tracking done");
  endtask : t_delay

  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    $display("Error watchdog expected end seen hang");
    complete_run;
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, hfosc_tick} = 7'h00;
    {timer0_overflow, timer2_overflow, timer3_overflow} = 3'h0;
    {external_convert_start_pin, sar_done, sar_burst_last, window_match} = 4'h0;
    {awaddr, araddr, wdata, wstrb} = {12'h000, 12'h000, 32'h0, 4'hF};
    {mismatches, compares, cyc, starts, last_tick, tick_gap, trk_ticks} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_regs;
    t_sources;
    t_burst;
    t_delay;
    complete_run;
  end
endmodule : acc_adc_control_tb_top
`default_nettype wire
